// ===== rtl/pvpp_port.v
// Parallel high-voltage programming port with page buffer and memory model
`timescale 1ns/1ps
`default_nettype none
`include "pvpp_defines.vh"
module pvpp_port #(
  parameter PAGE_BITS  = 7,
  parameter FADDR_BITS = 10,
  parameter EADDR_BITS = 8,
  parameter PROG_CYC   = 8000,
  parameter ERASE_CYC  = 9000
) (
  input  wire       CLK_SYS_I,
  input  wire       RESET_I,
  input  wire       HV_PRESENT_I,
  input  wire       LOAD_STROBE_INPUT_I,
  input  wire       WR_N_I,
  input  wire       OE_N_I,
  input  wire       PAGE_LATCH_STROBE_I,
  input  wire       ACTION_SELECT_HI_I,
  input  wire       ACTION_SELECT_LO_I,
  input  wire       BYTE_SELECT_FIRST_I,
  input  wire       BYTE_SELECT_SECOND_I,
  input  wire [7:0] DATA_I,
  output reg  [7:0] DATA_O,
  output reg        DATA_OE_N_O,
  output reg        READY_BUSY_OUT_O,
  output reg        PROG_MODE_O
);
  // ************************************************************
  // Identity (values arbitrary)
  // ************************************************************
  localparam [7:0] SIG0 = `PVPP_SIG0_VAL;
  localparam [7:0] SIG1 = `PVPP_SIG1_VAL;
  localparam [7:0] SIG2 = `PVPP_SIG2_VAL;
  localparam [7:0] CAL0 = `PVPP_CAL0_VAL;
  localparam [31:0] LATCH_CYC = `PVPP_LATCH_CYC;
  localparam ST_OFF = 3'h1;
  localparam ST_LATCH = 3'h2;
  localparam ST_ON = 3'h4;
  localparam FW = 1 << FADDR_BITS;
  localparam EW = 1 << EADDR_BITS;
  localparam PW = 1 << PAGE_BITS;

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  reg [10:0] s1_reg;
  reg [10:0] s2_reg;
  reg        stb_d_reg;
  reg        wr_d_reg;
  reg        pl_d_reg;
  // Every pin but RESET_I crosses two flops before logic looks at it
  always @(posedge CLK_SYS_I)
  begin
    s1_reg <= {HV_PRESENT_I, LOAD_STROBE_INPUT_I, WR_N_I, OE_N_I, PAGE_LATCH_STROBE_I,
               ACTION_SELECT_HI_I, ACTION_SELECT_LO_I, BYTE_SELECT_FIRST_I,
               BYTE_SELECT_SECOND_I, 2'h0};
    s2_reg <= s1_reg;
  end
  reg [7:0] din_s1_reg;
  reg [7:0] din_reg;
  always @(posedge CLK_SYS_I)
  begin
    din_s1_reg <= DATA_I;
    din_reg <= din_s1_reg;
  end
  wire hv = s2_reg[10];
  wire stb = s2_reg[9];
  wire wr_n = s2_reg[8];
  wire oe_n = s2_reg[7];
  wire pl = s2_reg[6];
  wire [1:0] act = s2_reg[5:4];
  wire sel1 = s2_reg[3];
  wire sel2 = s2_reg[2];
  always @(posedge CLK_SYS_I)
  begin
    stb_d_reg <= RESET_I ? 1'b0 : stb;
    wr_d_reg <= RESET_I ? 1'b1 : wr_n;
    pl_d_reg <= RESET_I ? 1'b0 : pl;
  end
  wire stb_rise = stb & ~stb_d_reg;
  wire wr_fall = wr_d_reg & ~wr_n;
  wire pl_rise = pl & ~pl_d_reg;

  // ************************************************************
  // Mode entry and exit
  // ************************************************************
  reg [2:0]  mode_reg;
  reg [31:0] lcnt_reg;
  reg        sig_ok_reg;
  // Signature is checked over the whole latch window, not a single sample
  always @(posedge CLK_SYS_I)
  begin
    if (RESET_I || !hv)
    begin
      mode_reg <= ST_OFF;
      lcnt_reg <= 32'h0;
      sig_ok_reg <= 1'b0;
    end
    else
    begin
      case (mode_reg)
        ST_OFF:
        begin
          mode_reg <= ST_LATCH;
          lcnt_reg <= 32'h0;
          sig_ok_reg <= 1'b1;
        end
        ST_LATCH:
        begin
          if (pl | act[1] | act[0] | sel1)
            sig_ok_reg <= 1'b0;
          lcnt_reg <= lcnt_reg + 32'h1;
          // A failed signature parks here, so later pin moves never enter the mode
          if (lcnt_reg == LATCH_CYC - 32'h1)
            mode_reg <= (sig_ok_reg & ~(pl | act[1] | act[0] | sel1)) ? ST_ON : ST_LATCH;
        end
        ST_ON:
          mode_reg <= ST_ON;
        default:
          mode_reg <= ST_OFF;
      endcase
    end
  end
  wire on = (mode_reg == ST_ON) & hv;

  // ************************************************************
  // Memories and nonvolatile bits
  // ************************************************************
  reg [15:0] flash_mem [0:FW-1];
  reg [7:0]  ee_mem [0:EW-1];
  reg [15:0] page_mem [0:PW-1];
  reg [7:0]  fuse_lo_reg;
  reg [7:0]  fuse_hi_reg;
  reg [7:0]  fuse_ex_reg;
  reg [7:0]  lock_reg;
  reg [7:0]  cmd_reg;
  reg [7:0]  alo_reg;
  reg [7:0]  ahi_reg;
  reg [7:0]  aex_reg;
  reg [7:0]  dlo_reg;
  reg [7:0]  dhi_reg;
  reg        busy_reg;
  reg [31:0] bcnt_reg;
  reg [7:0]  op_reg;
  reg [FADDR_BITS:0] eidx_reg;
  reg        sel1_op_reg;
  reg        sel2_op_reg;
  wire [23:0] addr = {aex_reg, ahi_reg, alo_reg};
  wire [FADDR_BITS-1:0] faddr = addr[FADDR_BITS-1:0];
  wire [EADDR_BITS-1:0] eaddr = addr[EADDR_BITS-1:0];
  wire [PAGE_BITS-1:0] pword = addr[PAGE_BITS-1:0];
  wire [FADDR_BITS-1:0] pbase = {faddr[FADDR_BITS-1:PAGE_BITS], {PAGE_BITS{1'b0}}};
  integer i;

  // Load, latch and operation sequencing; all state kept until rewritten
  always @(posedge CLK_SYS_I)
  begin
    if (RESET_I)
    begin
      fuse_lo_reg <= `PVPP_FUSE_LO_RST;
      fuse_hi_reg <= `PVPP_FUSE_HI_RST;
      fuse_ex_reg <= `PVPP_FUSE_EX_RST;
      lock_reg <= `PVPP_LOCK_RST;
      cmd_reg <= `PVPP_CMD_NOP;
      alo_reg <= 8'h00;
      ahi_reg <= 8'h00;
      aex_reg <= 8'h00;
      dlo_reg <= 8'hff;
      dhi_reg <= 8'hff;
      busy_reg <= 1'b0;
      bcnt_reg <= 32'h0;
      op_reg <= 8'h00;
      eidx_reg <= {(FADDR_BITS+1){1'b0}};
      sel1_op_reg <= 1'b0;
      sel2_op_reg <= 1'b0;
    end
    else if (busy_reg)
    begin
      // Erase walks the array a word per cycle, so lock release follows it
      if (op_reg == `PVPP_CMD_ERASE)
      begin
        if (!eidx_reg[FADDR_BITS])
        begin
          flash_mem[eidx_reg[FADDR_BITS-1:0]] <= 16'hffff;
          if (fuse_hi_reg[`PVPP_EE_KEEP_BIT])
            ee_mem[eidx_reg[EADDR_BITS-1:0]] <= 8'hff;
          eidx_reg <= eidx_reg + 1'b1;
        end
        else
        begin
          lock_reg <= 8'hff;
          busy_reg <= 1'b0;
        end
      end
      else
      begin
        bcnt_reg <= bcnt_reg + 32'h1;
        if (bcnt_reg == PROG_CYC - 1)
        begin
          busy_reg <= 1'b0;
          if (op_reg == `PVPP_CMD_WR_FLASH)
            for (i = 0; i < PW; i = i + 1)
              flash_mem[pbase | i[FADDR_BITS-1:0]] <= page_mem[i];
          else if (op_reg == `PVPP_CMD_WR_EE)
            ee_mem[eaddr] <= dlo_reg;
          else if (op_reg == `PVPP_CMD_WR_FUSE)
          begin
            if (!sel1_op_reg && !sel2_op_reg)
              fuse_lo_reg <= dlo_reg;
            else if (sel1_op_reg && !sel2_op_reg)
              fuse_hi_reg <= dlo_reg;
            else if (!sel1_op_reg && sel2_op_reg)
              fuse_ex_reg <= dlo_reg;
          end
          else if (op_reg == `PVPP_CMD_WR_LOCK)
            lock_reg <= lock_reg & dlo_reg;
        end
      end
    end
    else if (on)
    begin
      if (stb_rise)
      begin
        if (act == `PVPP_ACT_CMD)
          cmd_reg <= din_reg;
        else if (act == `PVPP_ACT_ADDR)
        begin
          if (!sel2 && !sel1)
            alo_reg <= din_reg;
          else if (!sel2 && sel1)
            ahi_reg <= din_reg;
          else if (sel2 && !sel1)
            aex_reg <= din_reg;
        end
        else if (act == `PVPP_ACT_DATA && !sel2)
        begin
          if (sel1)
            dhi_reg <= din_reg;
          else
            dlo_reg <= din_reg;
        end
      end
      if (pl_rise && sel1 && cmd_reg == `PVPP_CMD_WR_FLASH)
        page_mem[pword] <= {dhi_reg, dlo_reg};
      if (wr_fall)
      begin
        op_reg <= cmd_reg;
        sel1_op_reg <= sel1;
        sel2_op_reg <= sel2;
        bcnt_reg <= 32'h0;
        eidx_reg <= {(FADDR_BITS+1){1'b0}};
        // Only erase and write commands make the device busy
        if (cmd_reg == `PVPP_CMD_ERASE || cmd_reg == `PVPP_CMD_WR_FUSE ||
            cmd_reg == `PVPP_CMD_WR_LOCK || cmd_reg == `PVPP_CMD_WR_FLASH ||
            cmd_reg == `PVPP_CMD_WR_EE)
          busy_reg <= 1'b1;
      end
    end
  end

  // ************************************************************
  // Read path and outputs
  // ************************************************************
  reg [7:0] rd;
  reg [15:0] fw;
  always @*
  begin
    fw = flash_mem[faddr];
    rd = 8'hff;
    if (cmd_reg == `PVPP_CMD_RD_FLASH)
      rd = sel1 ? fw[15:8] : fw[7:0];
    else if (cmd_reg == `PVPP_CMD_RD_EE)
      rd = ee_mem[eaddr];
    else if (cmd_reg == `PVPP_CMD_RD_SIG)
    begin
      if (sel1)
        rd = (alo_reg == 8'h00) ? CAL0 : 8'hff;
      else if (alo_reg == 8'h00)
        rd = SIG0;
      else if (alo_reg == 8'h01)
        rd = SIG1;
      else if (alo_reg == 8'h02)
        rd = SIG2;
    end
    else if (cmd_reg == `PVPP_CMD_RD_FUSE)
    begin
      if (!sel2 && !sel1)
        rd = fuse_lo_reg;
      else if (!sel2 && sel1)
        rd = lock_reg;
      else if (sel2 && !sel1)
        rd = fuse_ex_reg;
      else
        rd = fuse_hi_reg;
    end
  end
  // Registered outputs add a few cycles of latency after the pins move
  always @(posedge CLK_SYS_I)
  begin
    if (RESET_I)
    begin
      DATA_O <= 8'h00;
      DATA_OE_N_O <= 1'b1;
      READY_BUSY_OUT_O <= 1'b1;
      PROG_MODE_O <= 1'b0;
    end
    else
    begin
      DATA_O <= rd;
      DATA_OE_N_O <= ~(on & ~oe_n);
      READY_BUSY_OUT_O <= ~busy_reg;
      PROG_MODE_O <= on;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/pvpp_defines.vh
// Constants of the parallel high-voltage programming port
`ifndef PVPP_DEFINES_VH
`define PVPP_DEFINES_VH
`define PVPP_ACT_ADDR     2'h0
`define PVPP_ACT_DATA     2'h1
`define PVPP_ACT_CMD      2'h2
`define PVPP_CMD_ERASE    8'h80
`define PVPP_CMD_WR_FUSE  8'h40
`define PVPP_CMD_WR_LOCK  8'h20
`define PVPP_CMD_WR_FLASH 8'h10
`define PVPP_CMD_WR_EE    8'h11
`define PVPP_CMD_RD_SIG   8'h08
`define PVPP_CMD_RD_FUSE  8'h04
`define PVPP_CMD_RD_FLASH 8'h02
`define PVPP_CMD_RD_EE    8'h03
`define PVPP_CMD_NOP      8'h00
`define PVPP_LATCH_NS     10000
`define PVPP_CLK_MHZ      250
`define PVPP_LATCH_CYC    ((`PVPP_LATCH_NS * `PVPP_CLK_MHZ + 999) / 1000)
`define PVPP_FUSE_LO_RST  8'h62
`define PVPP_FUSE_HI_RST  8'hff
`define PVPP_FUSE_EX_RST  8'hff
`define PVPP_LOCK_RST     8'hff
`define PVPP_EE_KEEP_BIT  3
// Identity bytes; values arbitrary
`define PVPP_SIG0_VAL     8'ha5
`define PVPP_SIG1_VAL     8'h5a
`define PVPP_SIG2_VAL     8'h3c
`define PVPP_CAL0_VAL     8'h80
`endif

// ===== test/pvpp_port_checker.sv
// Pin-level checker for the programming port
`timescale 1ns/1ps
`default_nettype none
module pvpp_port_checker (
  input wire logic CLK_SYS_I,
  input wire logic RESET_I,
  input wire logic HV_PRESENT_I,
  input wire logic WR_N_I,
  input wire logic OE_N_I,
  input wire logic PAGE_LATCH_STROBE_I,
  input wire logic ACTION_SELECT_HI_I,
  input wire logic ACTION_SELECT_LO_I,
  input wire logic BYTE_SELECT_FIRST_I,
  input wire logic DATA_OE_N_O,
  input wire logic READY_BUSY_OUT_O,
  input wire logic PROG_MODE_O
);
  // ****
  // Properties on the system clock
  // ****
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (RESET_I);
  // Synchroniser plus register gives three cycles of slack
  property p_exit; !HV_PRESENT_I [*4] |-> !PROG_MODE_O; endproperty
  a_exit: assert property (p_exit) else $error("mode kept without voltage");
  property p_entry; $rose(PROG_MODE_O) |-> HV_PRESENT_I && ({PAGE_LATCH_STROBE_I,
    ACTION_SELECT_HI_I, ACTION_SELECT_LO_I, BYTE_SELECT_FIRST_I} == 4'h0); endproperty
  a_entry: assert property (p_entry) else $error("mode entered without signature");
  property p_idle; $rose(PROG_MODE_O) |-> READY_BUSY_OUT_O && DATA_OE_N_O; endproperty
  a_idle: assert property (p_idle) else $error("mode entered busy or driving");
  property p_oe; OE_N_I [*4] |-> DATA_OE_N_O; endproperty
  a_oe: assert property (p_oe) else $error("bus driven without enable");
  property p_drv; !DATA_OE_N_O |-> PROG_MODE_O; endproperty
  a_drv: assert property (p_drv) else $error("bus driven outside mode");
  property p_start; $fell(READY_BUSY_OUT_O) |-> $past(!WR_N_I, 2) && PROG_MODE_O; endproperty
  a_start: assert property (p_start) else $error("busy without write strobe");
  property p_hold; $fell(READY_BUSY_OUT_O) |-> !READY_BUSY_OUT_O [*8]; endproperty
  a_hold: assert property (p_hold) else $error("busy too short");
  // Busy length is counted here; with the testbench's PROG_CYC of 20 the erase walk is the longest, about 1025 cycles
  logic [10:0] busy_cnt;
  always @(posedge CLK_SYS_I)
  begin
    if (RESET_I || READY_BUSY_OUT_O)
      busy_cnt <= 11'h000;
    else if (busy_cnt != 11'h7ff)
      busy_cnt <= busy_cnt + 11'h001;
  end
  property p_done; busy_cnt <= 11'h44c; endproperty
  a_done: assert property (p_done) else $error("busy never ends");
endmodule
bind pvpp_port pvpp_port_checker chk_u (.CLK_SYS_I, .RESET_I, .HV_PRESENT_I, .WR_N_I,
  .OE_N_I, .PAGE_LATCH_STROBE_I, .ACTION_SELECT_HI_I, .ACTION_SELECT_LO_I,
  .BYTE_SELECT_FIRST_I, .DATA_OE_N_O, .READY_BUSY_OUT_O, .PROG_MODE_O);
`default_nettype wire

// ===== test/pvpp_prog_model.sv
// Programmer model that drives the port pins
`timescale 1ns/1ps
`default_nettype none
module pvpp_prog_model (
  input  wire logic       clk_i,
  output var  logic       hv_o,
  output var  logic       strobe_o,
  output var  logic       wr_n_o,
  output var  logic       oe_n_o,
  output var  logic       latch_o,
  output var  logic       act_hi_o,
  output var  logic       act_lo_o,
  output var  logic       sel1_o,
  output var  logic       sel2_o,
  output wire logic [7:0] data_o
);
  logic [7:0] drv;
  // ****
  // Pin driving
  // ****
  // A released bus shows the inverted value, so a stale copy never passes
  assign data_o = oe_n_o ? drv : ~drv;
  // Signature pins low before power comes up
  initial
  begin
    {hv_o, strobe_o, latch_o, act_hi_o, act_lo_o, sel1_o, sel2_o, drv} = '0;
    {wr_n_o, oe_n_o} = 2'h3;
  end
  // Every change lands 1 ns after a rising edge
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // Voltage comes after reset, signature pins untouched, then the settle wait
  task automatic enter();
    hv_o = 1'b1;
    wt(75000);
  endtask
  task automatic leave();
    hv_o = 1'b0;
    wt(8);
  endtask
  // Selects and data settle before the strobe rises
  task automatic ld(input logic [1:0] a, input logic [1:0] b, input logic [7:0] d);
    {act_hi_o, act_lo_o} = a;
    {sel2_o, sel1_o} = b;
    drv = d;
    wt(8);
    strobe_o = 1'b1;
    wt(8);
    strobe_o = 1'b0;
    wt(8);
  endtask
  // Long enough to outlast the busy rise, short of the end of programming
  task automatic wr();
    wr_n_o = 1'b0;
    wt(8);
    wr_n_o = 1'b1;
    wt(8);
  endtask
  task automatic latch();
    sel1_o = 1'b1;
    wt(8);
    latch_o = 1'b1;
    wt(8);
    latch_o = 1'b0;
    wt(8);
  endtask
  // Byte selects and output enable move together, then settle
  task automatic pins(input logic [1:0] b, input logic n);
    {sel2_o, sel1_o} = b;
    oe_n_o = n;
    wt(8);
  endtask
endmodule
`default_nettype wire

// ===== test/test_parallel_hv_program_port.sv
// Self-checking testbench for the programming port
`timescale 1ns/1ps
`default_nettype none
`include "pvpp_defines.vh"
module test_parallel_hv_program_port;
  logic       clk;
  logic       rst;
  wire        hv, stb, wr_n, oe_n, pl, xh, xl, b1, b2, doe_n, rdy, mode;
  wire  [7:0] din, dout;
  int         failures = 0;
  int         check_count = 0;
  logic [7:0] q;
  // ****
  // Device, programmer and clock
  // ****
  pvpp_port #(.PROG_CYC(20)) dut_u (.CLK_SYS_I(clk), .RESET_I(rst), .HV_PRESENT_I(hv),
    .LOAD_STROBE_INPUT_I(stb), .WR_N_I(wr_n), .OE_N_I(oe_n), .PAGE_LATCH_STROBE_I(pl),
    .ACTION_SELECT_HI_I(xh), .ACTION_SELECT_LO_I(xl), .BYTE_SELECT_FIRST_I(b1),
    .BYTE_SELECT_SECOND_I(b2), .DATA_I(din), .DATA_O(dout), .DATA_OE_N_O(doe_n),
    .READY_BUSY_OUT_O(rdy), .PROG_MODE_O(mode));
  pvpp_prog_model prog_u (.clk_i(clk), .hv_o(hv), .strobe_o(stb), .wr_n_o(wr_n),
    .oe_n_o(oe_n), .latch_o(pl), .act_hi_o(xh), .act_lo_o(xl), .sel1_o(b1), .sel2_o(b2),
    .data_o(din));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Read with output enable low; data sampled once it has settled
  task automatic rd(input logic [1:0] b, input logic [7:0] exp);
    prog_u.pins(b, 1'b0);
    chk("drive", {7'h0, doe_n}, 8'h0);
    chk("read", dout, exp);
    prog_u.pins(b, 1'b1);
  endtask
  // Write strobe, then a bounded wait for ready
  task automatic run_op();
    int n;
    prog_u.wr();
    chk("busy", {7'h0, rdy}, 8'h0);
    n = 0;
    while (rdy !== 1'b1 && n < 2000)
    begin
      prog_u.wt(1);
      n++;
    end
    chk("ready", {7'h0, rdy}, 8'h1);
    if (n == 2000)
      results();
  endtask
  task automatic t_enter();
    prog_u.enter();
    chk("mode", {7'h0, mode}, 8'h1);
    chk("idle", {6'h0, rdy, doe_n}, 8'h3);
    $display("entry test done");
  endtask
  // Lock write, then every fuse and lock select
  task automatic t_lock();
    logic [7:0] exp [4];
    exp = '{8'h62, 8'hf0, 8'hff, 8'hff};
    prog_u.ld(2'h2, 2'h0, 8'h20);
    prog_u.ld(2'h1, 2'h0, 8'hf0);
    run_op();
    prog_u.ld(2'h2, 2'h0, 8'h04);
    for (int i = 0; i < 4; i++)
      rd(2'(i), exp[i]);
    prog_u.ld(2'h2, 2'h0, 8'h08);
    prog_u.ld(2'h0, 2'h0, 8'h02);
    rd(2'h0, `PVPP_SIG2_VAL);
    prog_u.ld(2'h0, 2'h0, 8'h00);
    rd(2'h1, `PVPP_CAL0_VAL);
    $display("lock test done");
  endtask
  // Erase clears memories and lock, keeps fuses; address kept across commands
  task automatic t_erase();
    prog_u.ld(2'h2, 2'h0, 8'h80);
    run_op();
    prog_u.ld(2'h2, 2'h0, 8'h02);
    prog_u.ld(2'h0, 2'h1, 8'h00);
    prog_u.ld(2'h0, 2'h0, 8'h05);
    rd(2'h0, 8'hff);
    prog_u.ld(2'h2, 2'h0, 8'h03);
    rd(2'h0, 8'hff);
    prog_u.ld(2'h2, 2'h0, 8'h04);
    rd(2'h1, 8'hff);
    rd(2'h0, 8'h62);
    $display("erase test done");
  endtask
  // Page write with an idle load mixed in, then an EEPROM byte
  task automatic t_flash();
    prog_u.ld(2'h2, 2'h0, 8'h10);
    prog_u.ld(2'h1, 2'h0, 8'h34);
    prog_u.ld(2'h1, 2'h1, 8'h12);
    prog_u.ld(2'h3, 2'h0, 8'h99);
    prog_u.latch();
    run_op();
    prog_u.ld(2'h2, 2'h0, 8'h02);
    rd(2'h0, 8'h34);
    rd(2'h1, 8'h12);
    prog_u.ld(2'h2, 2'h0, 8'h11);
    prog_u.ld(2'h1, 2'h0, 8'h5a);
    run_op();
    prog_u.ld(2'h2, 2'h0, 8'h03);
    rd(2'h0, 8'h5a);
    $display("write test done");
  endtask
  // Program the preserve fuse, then erase keeps EEPROM and fuses, clears Flash
  task automatic t_keep();
    prog_u.ld(2'h2, 2'h0, 8'h40);
    prog_u.ld(2'h1, 2'h0, 8'hf7);
    prog_u.pins(2'h1, 1'b1);
    run_op();
    prog_u.ld(2'h2, 2'h0, 8'h04);
    rd(2'h3, 8'hf7);
    prog_u.ld(2'h2, 2'h0, 8'h80);
    run_op();
    prog_u.ld(2'h2, 2'h0, 8'h03);
    rd(2'h0, 8'h5a);
    prog_u.ld(2'h2, 2'h0, 8'h02);
    rd(2'h0, 8'hff);
    prog_u.ld(2'h2, 2'h0, 8'h04);
    rd(2'h3, 8'hf7);
    $display("preserve test done");
  endtask
  initial
  begin
    rst = 1'b1;
    repeat (20) @(posedge clk);
    #1;
    rst = 1'b0;
    prog_u.wt(2);
    t_enter();
    t_lock();
    t_erase();
    t_flash();
    t_keep();
    prog_u.leave();
    chk("exit", {7'h0, mode}, 8'h0);
    $display("exit test done");
    results();
  end
endmodule
`default_nettype wire
